// ===== hdl/uart_command_response_link.v
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "uart_link_consts.vh"
module uart_command_response_link #(
  parameter [31:0] cmd_timeout_limit = `CMD_TIMEOUT_CYCLES,
  parameter [31:0] resp_start_limit = `RESP_START_CYCLES,
  parameter [31:0] response_time_limit = `RESP_LIMIT_CYCLES
) (
  input wire ref_clk,
  input wire resetn,
  input wire rxd,
  output reg txd,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire irq
);
  // ctrl: [1:0] parity, [2] two stop bits, [7:4] command length
  reg [7:0] ctrl;
  reg [4:0] status;
  reg [4:0] mask;
  reg [7:0] rx_byte;
  reg [3:0] resp_len;
  reg resp_go;
  wire [1:0] par_mode = ctrl[1:0];
  wire two_stop = ctrl[2];
  wire [3:0] cmd_len = ctrl[7:4];

  // parity bit for a byte under the selected mode
  function par_bit;
    input [7:0] b;
    input [1:0] m;
    begin
      par_bit = (m == `PAR_ODD) ? ~(^b) : (^b);
    end
  endfunction

  // input synchroniser
  reg rx_s1;
  reg rx_s2;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
    end
  end

  // receiver
  localparam [4:0] RS_IDLE = 5'h01;
  localparam [4:0] RS_START = 5'h02;
  localparam [4:0] RS_DATA = 5'h04;
  localparam [4:0] RS_PAR = 5'h08;
  localparam [4:0] RS_STOP = 5'h10;
  reg [4:0] rs;
  reg [10:0] rcnt;
  reg [2:0] rbit;
  reg [7:0] rsh;
  reg rpar_ok;
  reg rx_done;
  reg rx_ferr;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rs <= RS_IDLE;
      rcnt <= 11'h000;
      rbit <= 3'h0;
      rsh <= 8'h00;
      rpar_ok <= 1'b1;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      if (rcnt != 11'h000) begin
        rcnt <= rcnt - 11'h001;
      end
      case (rs)
        RS_IDLE: begin
          if (!rx_s2) begin
            rs <= RS_START;
            rcnt <= 11'd`HALF_BIT_CYCLES;
          end
        end
        RS_START: begin
          if (rcnt == 11'h000) begin
            if (rx_s2) begin
              rs <= RS_IDLE; // glitch, not a start bit
            end else begin
              rs <= RS_DATA;
              rbit <= 3'h0;
              rcnt <= 11'd`BIT_CYCLES;
            end
          end
        end
        RS_DATA: begin
          if (rcnt == 11'h000) begin
            rsh <= {rx_s2, rsh[7:1]};
            rcnt <= 11'd`BIT_CYCLES;
            rbit <= rbit + 3'h1;
            if (rbit == 3'h7) begin
              rs <= (par_mode == `PAR_NONE) ? RS_STOP : RS_PAR;
            end
          end
        end
        RS_PAR: begin
          if (rcnt == 11'h000) begin
            rpar_ok <= (rx_s2 == par_bit(rsh, par_mode));
            rs <= RS_STOP;
            rcnt <= 11'd`BIT_CYCLES;
          end
        end
        RS_STOP: begin
          if (rcnt == 11'h000) begin
            rs <= RS_IDLE;
            if (rx_s2 && rpar_ok) begin
              rx_done <= 1'b1;
              rx_byte <= rsh;
            end else begin
              rx_ferr <= 1'b1;
            end
            rpar_ok <= 1'b1;
          end
        end
        default: begin
          rs <= RS_IDLE;
        end
      endcase
    end
  end

  // command assembly and timeout
  reg [3:0] rx_cnt;
  reg [31:0] cmd_tmr;
  reg cmd_active;
  reg cmd_done;
  reg cmd_tout;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_cnt <= 4'h0;
      cmd_tmr <= 32'h0;
      cmd_active <= 1'b0;
      cmd_done <= 1'b0;
      cmd_tout <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      cmd_tout <= 1'b0;
      if (rx_done) begin
        if (!cmd_active) begin
          cmd_tmr <= 32'h0;
        end
        if (rx_cnt + 4'h1 >= cmd_len) begin
          cmd_done <= 1'b1;
          cmd_active <= 1'b0;
          rx_cnt <= 4'h0;
        end else begin
          cmd_active <= 1'b1;
          rx_cnt <= rx_cnt + 4'h1;
        end
      end else if (cmd_active) begin
        cmd_tmr <= cmd_tmr + 32'h1;
        if (cmd_tmr >= cmd_timeout_limit - 32'h1) begin
          cmd_active <= 1'b0; // queue dropped
          rx_cnt <= 4'h0;
          cmd_tout <= 1'b1;
        end
      end
    end
  end

  // response store
  reg [3:0] tx_idx;
  wire [7:0] mem_q;
  wire mem_we = wr && (addr == `REG_TXDATA);
  reg [3:0] mem_wa;
  byte_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(wdata),
    .rd_addr(tx_idx),
    .rd_data(mem_q)
  );

  // response sequencer and transmitter
  localparam [6:0] TS_IDLE = 7'h01;
  localparam [6:0] TS_LOAD = 7'h02;
  localparam [6:0] TS_START = 7'h04;
  localparam [6:0] TS_DATA = 7'h08;
  localparam [6:0] TS_PAR = 7'h10;
  localparam [6:0] TS_STOP = 7'h20;
  localparam [6:0] TS_HOLD = 7'h40;
  reg [6:0] ts;
  reg [10:0] tcnt;
  reg [2:0] tbit;
  reg [7:0] tsh;
  reg stop2;
  reg err_pend;
  reg err_mode;
  reg resp_pend;
  reg [31:0] resp_tmr;
  reg tx_done_ev;
  reg late_ev;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ts <= TS_IDLE;
      txd <= 1'b1;
      tcnt <= 11'h000;
      tbit <= 3'h0;
      tsh <= 8'h00;
      stop2 <= 1'b0;
      tx_idx <= 4'h0;
      err_pend <= 1'b0;
      err_mode <= 1'b0;
      resp_pend <= 1'b0;
      resp_tmr <= 32'h0;
      tx_done_ev <= 1'b0;
      late_ev <= 1'b0;
    end else begin
      tx_done_ev <= 1'b0;
      late_ev <= 1'b0;
      if (cmd_tout) begin
        err_pend <= 1'b1;
      end
      if (cmd_done) begin
        resp_pend <= 1'b1;
        resp_tmr <= 32'h0;
      end else if (ts != TS_IDLE || resp_pend) begin
        resp_tmr <= resp_tmr + 32'h1;
      end
      if (resp_pend && ts == TS_IDLE &&
          resp_tmr == resp_start_limit) begin
        late_ev <= 1'b1;
      end
      if (ts != TS_IDLE && !err_mode &&
          resp_tmr == response_time_limit) begin
        late_ev <= 1'b1;
      end
      if (tcnt != 11'h000) begin
        tcnt <= tcnt - 11'h001;
      end
      case (ts)
        TS_IDLE: begin
          txd <= 1'b1;
          if (err_pend && !cmd_tout) begin
            err_pend <= 1'b0;
            err_mode <= 1'b1;
            tsh <= `ERROR_BYTE;
            ts <= TS_START;
          end else if (resp_pend && resp_go && resp_len != 4'h0) begin
            resp_pend <= 1'b0;
            err_mode <= 1'b0;
            ts <= TS_LOAD;
          end
        end
        TS_LOAD: begin
          if (tcnt == 11'h000) begin // memory data trail the index
            tsh <= mem_q;
            ts <= TS_START;
          end
        end
        TS_START: begin
          txd <= 1'b0;
          tcnt <= 11'd`BIT_CYCLES - 11'h001;
          tbit <= 3'h0;
          ts <= TS_DATA;
        end
        TS_DATA: begin
          if (tcnt == 11'h000) begin
            txd <= tsh[tbit];
            tcnt <= 11'd`BIT_CYCLES - 11'h001;
            tbit <= tbit + 3'h1;
            if (tbit == 3'h7) begin
              ts <= (par_mode == `PAR_NONE) ? TS_STOP : TS_PAR;
            end
          end
        end
        TS_PAR: begin
          if (tcnt == 11'h000) begin
            txd <= par_bit(tsh, par_mode);
            tcnt <= 11'd`BIT_CYCLES - 11'h001;
            ts <= TS_STOP;
          end
        end
        TS_STOP: begin
          if (tcnt == 11'h000) begin
            txd <= 1'b1;
            tcnt <= 11'd`BIT_CYCLES - 11'h001;
            stop2 <= two_stop;
            ts <= TS_HOLD;
          end
        end
        TS_HOLD: begin
          // stop bit period, second one if selected
          if (tcnt == 11'h000) begin
            if (stop2) begin
              stop2 <= 1'b0;
              tcnt <= 11'd`BIT_CYCLES - 11'h001;
            end else if (!err_mode && tx_idx + 4'h1 < resp_len) begin
              tx_idx <= tx_idx + 4'h1;
              ts <= TS_LOAD;
              tcnt <= 11'h002;
            end else begin
              ts <= TS_IDLE;
              tx_idx <= 4'h0;
              tx_done_ev <= 1'b1;
            end
          end
        end
        default: begin
          ts <= TS_IDLE;
        end
      endcase
    end
  end

  // software registers, status set wins over clear
  wire [4:0] ev = {late_ev, tx_done_ev, cmd_tout, rx_ferr, rx_done};
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET;
      status <= 5'h00;
      mask <= 5'h00;
      resp_len <= 4'h0;
      resp_go <= 1'b0;
      mem_wa <= 4'h0;
      rdata <= 8'h00;
    end else begin
      if (wr && addr == `REG_STATUS) begin
        status <= (status & ~wdata[4:0]) | ev;
      end else begin
        status <= status | ev;
      end
      if (wr && addr == `REG_CTRL) begin
        ctrl <= wdata;
      end
      if (wr && addr == `REG_MASK) begin
        mask <= wdata[4:0];
      end
      if (mem_we) begin
        mem_wa <= mem_wa + 4'h1;
      end
      // cmd: [3:0] response length, [4] release response
      if (wr && addr == `REG_CMD) begin
        resp_len <= wdata[3:0];
        resp_go <= wdata[4];
        mem_wa <= 4'h0;
      end else if (ts == TS_LOAD && tx_idx == 4'h0) begin
        resp_go <= 1'b0;
      end
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `REG_CTRL: rdata <= ctrl;
          `REG_STATUS: rdata <= {3'h0, status};
          `REG_MASK: rdata <= {3'h0, mask};
          `REG_RXDATA: rdata <= rx_byte;
          `REG_CMD: rdata <= {2'h0, resp_pend, resp_go, resp_len};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  assign irq = |(status & mask);
endmodule // uart_command_response_link

// ===== hdl/uart_link_consts.vh
// Summary of operation
// - frame starts with one low start bit, data sent lsb first
// - optional parity bit follows data, stop bit always high
// - next frame may follow at once or after idle high
// - every frame carries exactly eight data bits
// - one or two stop bits selectable, both ends must agree
// - parity odd, even or none selectable, both ends must agree
// - bit rate at most 128000 baud, within one percent
// - command spans frames, response sent as consecutive frames
// - incomplete command after 15 ms is discarded, error byte sent
// - no response before first command frame received
// - response starts within 5 ms after last command frame
// - whole response finished within 10 ms
`ifndef UART_LINK_CONSTS_VH
`define UART_LINK_CONSTS_VH
`define CLK_HZ 250000000
`define BAUD_MAX 128000
`define BIT_CYCLES 1953
`define HALF_BIT_CYCLES 976
`define DATA_BITS 8
`define CMD_TIMEOUT_MS 15
`define CMD_TIMEOUT_CYCLES (`CMD_TIMEOUT_MS * (`CLK_HZ / 1000))
`define RESP_START_MS 5
`define RESP_START_CYCLES (`RESP_START_MS * (`CLK_HZ / 1000))
`define RESP_LIMIT_MS 10
`define RESP_LIMIT_CYCLES (`RESP_LIMIT_MS * (`CLK_HZ / 1000))
`define ERROR_BYTE 8'hab
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_RXDATA 4'h3
`define REG_TXDATA 4'h4
`define REG_CMD 4'h5
`define CTRL_RESET 8'h00
`define ST_RX 0
`define ST_FRAME_ERR 1
`define ST_TIMEOUT 2
`define ST_TX_DONE 3
`define ST_LATE 4
`endif

// ===== hdl/byte_mem.v
`timescale 1ns/10ps
// small response store, registered read data
module byte_mem (
  input wire ref_clk,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:15];
  // write port
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // registered read
  always @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // byte_mem

// ===== dv/uart_link_chk.sv
`timescale 1ns/10ps
`include "uart_link_consts.vh"
module uart_link_chk (
  input wire ref_clk,
  input wire resetn,
  input wire rxd,
  input wire txd,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire irq
);
  reg txd_q;
  reg seen_rx;
  reg [31:0] run;
  reg [7:0] ctrl_sh;
  // txd level run length, host activity, control shadow
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
      seen_rx <= 1'b0;
      run <= 32'h0;
      ctrl_sh <= `CTRL_RESET;
    end else begin
      txd_q <= txd;
      run <= (txd != txd_q) ? 32'h1 : run + 32'h1;
      if (!rxd)
        seen_rx <= 1'b1;
      if (wr && addr == `REG_CTRL)
        ctrl_sh <= wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_idle_after_reset: assert property ($rose(resetn) |-> txd)
    else $error("txd not idle high after reset");
  chk_low_run_bits: assert property ((txd && !txd_q) |->
    (run % `BIT_CYCLES == 0 && run <= 10 * `BIT_CYCLES))
    else $error("low run on txd not whole bit periods");
  chk_stop_before_start: assert property ((!txd && txd_q) |->
    run >= `BIT_CYCLES)
    else $error("start bit without a full high stop bit");
  chk_no_early_tx: assert property ($fell(txd) |-> seen_rx)
    else $error("response began before any host frame");
  chk_ctrl_readback: assert property ((rd && addr == `REG_CTRL) |=>
    rdata == ctrl_sh)
    else $error("control register readback wrong");
  chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property ((rd && addr > `REG_CMD) |=>
    rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_off_irq: assert property ((wr && addr == `REG_MASK &&
    wdata == 8'h00) |=> !irq)
    else $error("irq with all sources masked");
  cover property ($rose(irq));
  cover property ($fell(txd));
  cover property (rd && addr == `REG_STATUS);
endmodule // uart_link_chk

// ===== dv/host_model.sv
`timescale 1ns/10ps
`include "uart_link_consts.vh"
module host_model (
  input wire ref_clk,
  input wire txd,
  input wire [1:0] par,
  input wire two_stop,
  output reg rxd
);
  reg [7:0] got;
  reg got_err;
  integer got_count;
  integer i;
  integer j;
  // line idles high
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_err = 1'b0;
    got_count = 0;
  end
  function pbit(input [7:0] b, input [1:0] m);
    pbit = (m == `PAR_ODD) ? ~^b : ^b;
  endfunction
  task bit_out(input v);
    rxd <= v;
    repeat (`BIT_CYCLES) @(posedge ref_clk);
  endtask
  // one whole frame, optionally with a low stop bit
  task send_byte(input [7:0] b, input bad);
    @(posedge ref_clk);
    bit_out(1'b0);
    for (i = 0; i < 8; i = i + 1)
      bit_out(b[i]);
    if (par != `PAR_NONE)
      bit_out(pbit(b, par));
    bit_out(!bad);
    if (two_stop)
      bit_out(1'b1);
    rxd <= 1'b1;
  endtask
  // sample response frames mid bit and flag any fault
  always @(negedge txd) begin
    repeat (`HALF_BIT_CYCLES) @(posedge ref_clk);
    got_err = txd;
    for (j = 0; j < 8; j = j + 1) begin
      repeat (`BIT_CYCLES) @(posedge ref_clk);
      got[j] = txd;
    end
    if (par != `PAR_NONE) begin
      repeat (`BIT_CYCLES) @(posedge ref_clk);
      if (txd !== pbit(got, par))
        got_err = 1'b1;
    end
    repeat (`BIT_CYCLES) @(posedge ref_clk);
    if (txd !== 1'b1)
      got_err = 1'b1;
    if (two_stop) begin
      repeat (`BIT_CYCLES) @(posedge ref_clk);
      if (txd !== 1'b1)
        got_err = 1'b1;
    end
    got_count = got_count + 1;
  end
endmodule // host_model

// ===== dv/uart_command_response_link_tb.sv
`timescale 1ns/10ps
`include "uart_link_consts.vh"
module uart_command_response_link_tb;
  reg ref_clk;
  reg resetn;
  reg [3:0] addr;
  reg [7:0] wdata;
  reg wr;
  reg rd;
  reg [1:0] par;
  reg two_stop;
  reg [7:0] v;
  wire rxd;
  wire txd;
  wire [7:0] rdata;
  wire irq;
  integer fail_count;
  integer total_checks;
  integer cycles;
  integer n;
  uart_command_response_link #(
    .cmd_timeout_limit(32'd4000),
    .resp_start_limit(32'd8000),
    .response_time_limit(32'd60000)
  ) uart_command_response_link_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rxd(rxd),
    .txd(txd),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .irq(irq)
  );
  host_model host_model_inst (
    .ref_clk(ref_clk),
    .txd(txd),
    .par(par),
    .two_stop(two_stop),
    .rxd(rxd)
  );
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 100000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string name, input [7:0] e, input [7:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %0s exp %h got %h", name, e, g);
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task wait_rx(input integer c);
    for (n = 0; n < 60000 && host_model_inst.got_count == c; n = n + 1)
      @(posedge ref_clk);
    if (host_model_inst.got_count == c) begin
      fail_count = fail_count + 1;
      $display("MISMATCH frame count exp %0d got %0d", c + 1, c);
    end
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    par = `PAR_EVEN;
    two_stop = 1'b0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("txd idle", 8'h01, {7'h0, txd});
    rd_reg(`REG_CTRL);
    chk("ctrl reset", `CTRL_RESET, v);
    rd_reg(4'hf);
    chk("unmapped", 8'h00, v);
    // one-frame command, even parity
    wr_reg(`REG_CTRL, 8'h12);
    wr_reg(`REG_MASK, 8'h01);
    host_model_inst.send_byte(8'h5a, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk("irq rx", 8'h01, {7'h0, irq});
    rd_reg(`REG_STATUS);
    chk("status rx", 8'h01, v);
    rd_reg(`REG_RXDATA);
    chk("rx byte", 8'h5a, v);
    // response sent while host sends a frame with low stop bit
    wr_reg(`REG_STATUS, 8'hff);
    wr_reg(`REG_CTRL, 8'h10);
    par <= `PAR_NONE;
    wr_reg(`REG_TXDATA, 8'h3c);
    wr_reg(`REG_CMD, 8'h11);
    fork
      host_model_inst.send_byte(8'hc3, 1'b1);
      wait_rx(0);
    join
    chk("resp byte", 8'h3c, host_model_inst.got);
    chk("resp err", 8'h00, {7'h0, host_model_inst.got_err});
    repeat (`BIT_CYCLES) @(posedge ref_clk);
    rd_reg(`REG_STATUS);
    chk("status resp", 8'h0a, v);
    rd_reg(`REG_RXDATA);
    chk("rx dropped", 8'h5a, v);
    // two-frame command abandoned after one frame
    wr_reg(`REG_STATUS, 8'hff);
    wr_reg(`REG_CTRL, 8'h25);
    wr_reg(`REG_MASK, 8'h04);
    par <= `PAR_ODD;
    two_stop <= 1'b1;
    host_model_inst.send_byte(8'h11, 1'b0);
    wait_rx(1);
    chk("error byte", `ERROR_BYTE, host_model_inst.got);
    chk("err flags", 8'h00, {7'h0, host_model_inst.got_err});
    chk("irq timeout", 8'h01, {7'h0, irq});
    rd_reg(`REG_STATUS);
    chk("status tmo", 8'h04, v & 8'h04);
    rd_reg(`REG_RXDATA);
    chk("rx odd", 8'h11, v);
    wr_reg(`REG_MASK, 8'h00);
    #1;
    chk("irq masked", 8'h00, {7'h0, irq});
    repeat (2) @(posedge ref_clk);
    stop_test;
  end
endmodule // uart_command_response_link_tb
bind uart_command_response_link uart_link_chk uart_link_chk_inst (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .rxd(rxd),
  .txd(txd),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .irq(irq)
);
